// File: inc/wtd_pkg.sv
// Constants and carrier types for the wait table entry decoder.
// Assumes a 16-bit instruction word and a 10-bit code RAM address.
// Summary of operation
// - Five table rows, each a condition paired with a jump destination.
// - All five row conditions are evaluated together in every wait cycle.
// - The lowest enabled row whose condition holds jumps to its destination.
// - Row selector 000 to 100 selects rows one to five in order.
// - Far entry matches 000100 in bits 15:10, then register, row, condition.
// - Relative destination is the instruction's own address plus offset.
// - The 5-bit offset is two's complement, range minus sixteen to fifteen.
// - Relative rows store the computed address, no jump register.
// - Codes 0 to 15 test flags low, 16 to 31 test flags high.
// - Terminal counts, start low/high, ALU done and boost voltage codes.
// - Shortcut drain-source low, source low and drain-source high codes.
// - Current feedback high, low, and own current feedback codes.
// - Current shortcut instruction routes one block to own feedback.
// - Selector 00, 01, 10 pick blocks one to three; 11 block four low.
// - Reset route depends on core and channel, blocks one to four low.
// - Current shortcut matches 00110101011110 in bits 15:2, selector 1:0.
// - Far rows keep the chosen jump register holding the absolute address.
package wtd_pkg;
  localparam int ADDR_W = 10;
  localparam int ROWS = 5;
  localparam int ROW_W = 3;
  localparam int COND_W = 6;
  localparam int OFS_W = 5;
  localparam int REGS = 2;
  localparam int SYNC_W = 14;
  // Instruction fields
  localparam int FAR_OP_HI = 15;
  localparam int FAR_OP_LO = 10;
  localparam logic [5:0] FAR_OPCODE = 6'h04;
  localparam int FAR_REG_POS = 9;
  localparam int REL_OP_HI = 15;
  localparam int REL_OP_LO = 14;
  localparam logic [1:0] REL_OPCODE = 2'h3;
  localparam int OFS_HI = 13;
  localparam int OFS_LO = 9;
  localparam int ROW_HI = 8;
  localparam int ROW_LO = 6;
  localparam int COND_HI = 5;
  localparam int COND_LO = 0;
  localparam int CUR_OP_LO = 2;
  localparam logic [13:0] CUR_OPCODE = 14'h0D5E;
  localparam logic [2:0] ROW_LAST = 3'h4;
  // Condition code group bases
  localparam logic [5:0] C_FLAG_HI = 6'h10;
  localparam logic [5:0] C_TC = 6'h20;
  localparam logic [5:0] C_START_LO = 6'h24;
  localparam logic [5:0] C_START_HI = 6'h25;
  localparam logic [5:0] C_VDS_LO = 6'h26;
  localparam logic [5:0] C_SRC_LO = 6'h29;
  localparam logic [5:0] C_VDS_HI = 6'h2C;
  localparam logic [5:0] C_ALU = 6'h2F;
  localparam logic [5:0] C_VB_HI = 6'h30;
  localparam logic [5:0] C_VB_LO = 6'h31;
  localparam logic [5:0] C_CUR_HI = 6'h32;
  localparam logic [5:0] C_CUR_LO = 6'h38;
  localparam logic [5:0] C_OWN_HI = 6'h3E;
  localparam logic [5:0] C_OWN_LO = 6'h3F;

  typedef enum logic [1:0] {
    CUR_BLOCK_ONE, CUR_BLOCK_TWO, CUR_BLOCK_THREE, CUR_BLOCK_FOUR_LOW
  } wtd_cur_route_t;

  // Inputs that arrive from pins or analog comparators
  typedef struct packed {
    logic start;
    logic [2:0] scVds;
    logic [2:0] scSrc;
    logic boost;
    logic [5:0] curFb;
  } wtd_async_src_t;

  typedef struct packed {
    logic [15:0] flags;
    logic [3:0] termCount;
    logic aluDone;
    wtd_async_src_t ext;
    logic ownCur;
  } wtd_cond_src_t;

  typedef struct packed {
    logic valid;
    logic far;
    logic regSel;
    logic [COND_W-1:0] cond;
    logic [ADDR_W-1:0] addr;
  } wtd_row_t;
endpackage

// File: src/wtd_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs asynchronous to ref_clk; clkEn freezes all stages.
`timescale 1ns/1ps
module wtd_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else if (clkEn)
    begin
      s1_q <= asyncIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Output follows a bit only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : gBit
      always_ff @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
          syncOut[i] <= 1'b0;
        else if (clkEn && (s2_q[i] == s3_q[i]))
          syncOut[i] <= s3_q[i];
      end
    end
  endgenerate
endmodule

// File: src/wtd_cond_eval.sv
// Evaluates one six-bit wait condition code against the live sources.
// Purely combinational; sources already in the ref_clk domain.
`timescale 1ns/1ps
module wtd_cond_eval (
  input wire logic [5:0] cond,
  input wire wtd_pkg::wtd_cond_src_t src,
  output logic hit
);
  logic [5:0] ofs;

  always_comb
  begin
    hit = 1'b0;
    ofs = 6'h00;
    if (cond < wtd_pkg::C_FLAG_HI)
      hit = !src.flags[cond[3:0]];
    else if (cond < wtd_pkg::C_TC)
      hit = src.flags[cond[3:0]];
    else if (cond < wtd_pkg::C_START_LO)
      hit = src.termCount[cond[1:0]];
    else if (cond == wtd_pkg::C_START_LO)
      hit = !src.ext.start;
    else if (cond == wtd_pkg::C_START_HI)
      hit = src.ext.start;
    else if (cond < wtd_pkg::C_SRC_LO)
    begin
      ofs = cond - wtd_pkg::C_VDS_LO;
      hit = !src.ext.scVds[ofs[1:0]];
    end
    else if (cond < wtd_pkg::C_VDS_HI)
    begin
      ofs = cond - wtd_pkg::C_SRC_LO;
      hit = !src.ext.scSrc[ofs[1:0]];
    end
    else if (cond < wtd_pkg::C_ALU)
    begin
      ofs = cond - wtd_pkg::C_VDS_HI;
      hit = src.ext.scVds[ofs[1:0]];
    end
    else if (cond == wtd_pkg::C_ALU)
      hit = src.aluDone;
    else if (cond == wtd_pkg::C_VB_HI)
      hit = src.ext.boost;
    else if (cond == wtd_pkg::C_VB_LO)
      hit = !src.ext.boost;
    else if (cond < wtd_pkg::C_CUR_LO)
    begin
      ofs = cond - wtd_pkg::C_CUR_HI;
      hit = src.ext.curFb[ofs[2:0]];
    end
    else if (cond < wtd_pkg::C_OWN_HI)
    begin
      ofs = cond - wtd_pkg::C_CUR_LO;
      hit = !src.ext.curFb[ofs[2:0]];
    end
    else if (cond == wtd_pkg::C_OWN_HI)
      hit = src.ownCur;
    else
      hit = !src.ownCur;
  end
endmodule

// File: src/wtd_decoder.sv
// Wait table entry and current shortcut decoder for one microcore.
// Assumes the sequencer presents one instruction per valid cycle and
// holds waitActive with the row enable mask while in a wait.
`timescale 1ns/1ps
module wtd_decoder #(
  parameter logic CORE_ID = 1'b0,
  parameter logic CHANNEL_ID = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic [wtd_pkg::ADDR_W-1:0] instrAddr,
  input wire logic [wtd_pkg::REGS*wtd_pkg::ADDR_W-1:0] jumpRegisterSet,
  input wire logic waitActive,
  input wire logic [wtd_pkg::ROWS-1:0] waitRowEnable,
  input wire logic [15:0] flags,
  input wire logic [3:0] termCount,
  input wire logic aluDone,
  input wire wtd_pkg::wtd_async_src_t extAsync,
  output logic entryWritten,
  output logic routeWritten,
  output wtd_pkg::wtd_cur_route_t currentRouteSelector,
  output logic ownCurrentFeedback,
  output logic [wtd_pkg::ROWS-1:0] rowValid,
  output logic jumpValid,
  output logic [wtd_pkg::ROW_W-1:0] jumpRow,
  output logic [wtd_pkg::ADDR_W-1:0] jumpAddr
);
  localparam int AW = wtd_pkg::ADDR_W;
  localparam int NR = wtd_pkg::ROWS;

  // Reset route per core and channel
  localparam wtd_pkg::wtd_cur_route_t ROUTE_RESET =
    wtd_pkg::wtd_cur_route_t'({CHANNEL_ID, CORE_ID});

  wtd_pkg::wtd_row_t table_q [NR];
  wtd_pkg::wtd_cur_route_t route_q;
  wtd_pkg::wtd_async_src_t extSync;
  wtd_pkg::wtd_cond_src_t condSrc;
  logic [NR-1:0] rowHit;
  logic [NR-1:0] rowFire;
  logic isFar;
  logic isRel;
  logic isCur;
  logic rowOk;
  logic [wtd_pkg::ROW_W-1:0] rowSel;
  logic [wtd_pkg::COND_W-1:0] condSel;
  logic [AW-1:0] relAddr;
  logic anyFire;
  logic [wtd_pkg::ROW_W-1:0] firstRow;
  logic entryWritten_q;
  logic routeWritten_q;
  logic jumpValid_q;
  logic [wtd_pkg::ROW_W-1:0] jumpRow_q;
  logic [AW-1:0] jumpAddr_q;

  // Selected jump register content
  function automatic logic [AW-1:0] regValue(
    input logic sel,
    input logic [wtd_pkg::REGS*wtd_pkg::ADDR_W-1:0] regs
  );
    regValue = regs[sel*AW +: AW];
  endfunction

  // Resolved destination of a stored row
  function automatic logic [AW-1:0] rowDest(
    input wtd_pkg::wtd_row_t r,
    input logic [wtd_pkg::REGS*wtd_pkg::ADDR_W-1:0] regs
  );
    rowDest = r.far ? regValue(r.regSel, regs) : r.addr;
  endfunction

  wtd_sync3 #(
    .WIDTH(wtd_pkg::SYNC_W)
  ) uSync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .asyncIn(extAsync),
    .syncOut(extSync)
  );

  // Instruction decode
  assign isFar = instrValid && (instrWord[wtd_pkg::FAR_OP_HI:
    wtd_pkg::FAR_OP_LO] == wtd_pkg::FAR_OPCODE);
  assign isRel = instrValid && (instrWord[wtd_pkg::REL_OP_HI:
    wtd_pkg::REL_OP_LO] == wtd_pkg::REL_OPCODE);
  assign isCur = instrValid && (instrWord[wtd_pkg::FAR_OP_HI:
    wtd_pkg::CUR_OP_LO] == wtd_pkg::CUR_OPCODE);
  assign rowSel = instrWord[wtd_pkg::ROW_HI:wtd_pkg::ROW_LO];
  assign condSel = instrWord[wtd_pkg::COND_HI:wtd_pkg::COND_LO];
  // Codes above row five are not rows
  assign rowOk = (rowSel <= wtd_pkg::ROW_LAST);
  // Sign-extended offset added to own address, wrapping
  assign relAddr = instrAddr + AW'({{(AW-wtd_pkg::OFS_W){
    instrWord[wtd_pkg::OFS_HI]}},
    instrWord[wtd_pkg::OFS_HI:wtd_pkg::OFS_LO]});

  // Table writes
  genvar g;
  generate
    for (g = 0; g < NR; g++)
    begin : gRow
      always_ff @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
          table_q[g] <= '0;
        else if (clkEn && (isFar || isRel) && rowOk &&
                 (rowSel == wtd_pkg::ROW_W'(g)))
        begin
          table_q[g].valid <= 1'b1;
          table_q[g].far <= isFar;
          table_q[g].cond <= condSel;
          // Far rows keep the register choice, read at jump time
          table_q[g].regSel <= isFar &&
            instrWord[wtd_pkg::FAR_REG_POS];
          table_q[g].addr <= isFar ? '0 : relAddr;
        end
      end

      wtd_cond_eval uEval (
        .cond(table_q[g].cond),
        .src(condSrc),
        .hit(rowHit[g])
      );

      assign rowValid[g] = table_q[g].valid;
      assign rowFire[g] = waitActive && waitRowEnable[g] &&
        table_q[g].valid && rowHit[g];
    end
  endgenerate

  // Current route
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      route_q <= ROUTE_RESET;
    else if (clkEn && isCur)
      route_q <= wtd_pkg::wtd_cur_route_t'(instrWord[1:0]);
  end

  // Own feedback follows the routed block: 1, 2, 3 or 4 low
  always_comb
  begin
    condSrc.flags = flags;
    condSrc.termCount = termCount;
    condSrc.aluDone = aluDone;
    condSrc.ext = extSync;
    condSrc.ownCur = extSync.curFb[route_q];
  end

  // Lowest-numbered satisfied row wins
  always_comb
  begin
    anyFire = 1'b0;
    firstRow = '0;
    for (int i = NR - 1; i >= 0; i--)
    begin
      if (rowFire[i])
      begin
        anyFire = 1'b1;
        firstRow = wtd_pkg::ROW_W'(i);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      jumpValid_q <= 1'b0;
      jumpRow_q <= '0;
      jumpAddr_q <= '0;
    end
    else if (clkEn)
    begin
      jumpValid_q <= anyFire;
      if (anyFire)
      begin
        jumpRow_q <= firstRow;
        jumpAddr_q <= rowDest(table_q[firstRow], jumpRegisterSet);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      entryWritten_q <= 1'b0;
      routeWritten_q <= 1'b0;
    end
    else if (clkEn)
    begin
      entryWritten_q <= (isFar || isRel) && rowOk;
      routeWritten_q <= isCur;
    end
  end

  assign entryWritten = entryWritten_q;
  assign routeWritten = routeWritten_q;
  assign currentRouteSelector = route_q;
  assign ownCurrentFeedback = condSrc.ownCur;
  assign jumpValid = jumpValid_q;
  assign jumpRow = jumpRow_q;
  assign jumpAddr = jumpAddr_q;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  AST_FAR_ENTRY: assert property (
    clkEn && isFar && rowOk |=> table_q[$past(rowSel)].valid &&
      table_q[$past(rowSel)].far &&
      table_q[$past(rowSel)].cond == $past(condSel))
    else $error("far entry not stored");

  AST_FAR_REG: assert property (
    clkEn && isFar && rowOk |=> table_q[$past(rowSel)].regSel ==
      $past(instrWord[wtd_pkg::FAR_REG_POS]))
    else $error("far entry register select wrong");

  AST_REL_ADDR: assert property (
    clkEn && isRel && rowOk |=> !table_q[$past(rowSel)].far &&
      table_q[$past(rowSel)].addr == $past(instrAddr) +
      AW'($signed($past(instrWord[wtd_pkg::OFS_HI:wtd_pkg::OFS_LO]))))
    else $error("relative destination wrong");

  AST_BAD_ROW: assert property (
    clkEn && (isFar || isRel) && !rowOk |=> !entryWritten)
    else $error("illegal row written");

  AST_ROUTE_SET: assert property (
    clkEn && isCur |=> route_q == $past(instrWord[1:0]))
    else $error("current route not taken");

  AST_ROUTE_HOLD: assert property (
    !isCur ##1 1'b1 |-> $stable(route_q) || $past(!clkEn))
    else $error("current route changed without command");

  AST_JUMP_FIRE: assert property (
    clkEn && anyFire |=> jumpValid && jumpRow == $past(firstRow))
    else $error("satisfied row did not jump");

  AST_NO_JUMP: assert property (
    clkEn && !waitActive |=> !jumpValid)
    else $error("jump outside wait");

  AST_PRIORITY: assert property (
    jumpValid |-> ($past(rowFire) & ((5'h01 << jumpRow) - 5'h01)) == 5'h00)
    else $error("lower row skipped");

  AST_OWN_FB: assert property (
    ownCurrentFeedback == extSync.curFb[route_q])
    else $error("own feedback misrouted");

  AST_OWN_ONE: assert property (
    route_q == wtd_pkg::CUR_BLOCK_ONE |-> ownCurrentFeedback ==
      extSync.curFb[0])
    else $error("block one not routed");

  AST_OWN_TWO: assert property (
    route_q == wtd_pkg::CUR_BLOCK_TWO |-> ownCurrentFeedback ==
      extSync.curFb[1])
    else $error("block two not routed");

  AST_OWN_THREE: assert property (
    route_q == wtd_pkg::CUR_BLOCK_THREE |-> ownCurrentFeedback ==
      extSync.curFb[2])
    else $error("block three not routed");

  AST_OWN_FOUR: assert property (
    route_q == wtd_pkg::CUR_BLOCK_FOUR_LOW |-> ownCurrentFeedback ==
      extSync.curFb[3])
    else $error("block four low not routed");

  AST_ROUTE_RESET: assert property (
    $rose(rstn) |-> route_q == ROUTE_RESET && rowValid == '0)
    else $error("reset defaults wrong");

  AST_REL_ENTRY: assert property (
    clkEn && isRel && rowOk |=> table_q[$past(rowSel)].valid &&
      table_q[$past(rowSel)].cond == $past(condSel))
    else $error("relative entry not stored");

  AST_REL_NO_REG: assert property (
    clkEn && isRel && rowOk |=> !table_q[$past(rowSel)].regSel)
    else $error("relative entry kept a register");

  AST_ENTRY_PULSE: assert property (
    clkEn && (isFar || isRel) && rowOk |=> entryWritten)
    else $error("legal entry not reported");

  AST_ENTRY_QUIET: assert property (
    clkEn && !isFar && !isRel |=> !entryWritten)
    else $error("entry reported without entry word");

  AST_ROUTE_PULSE: assert property (
    clkEn && isCur |=> routeWritten)
    else $error("route write not reported");

  AST_ROUTE_QUIET: assert property (
    clkEn && !isCur |=> !routeWritten)
    else $error("route reported without route word");

  AST_ROWS_KEEP: assert property (
    clkEn && !((isFar || isRel) && rowOk) |=> $stable(rowValid))
    else $error("row state changed without entry");

  AST_ROWS_STICKY: assert property (
    (rowValid & $past(rowValid)) == $past(rowValid))
    else $error("written row lost");

  AST_FREEZE: assert property (
    !clkEn |=> $stable(route_q) && $stable(rowValid) &&
      $stable(jumpValid) && $stable(jumpAddr))
    else $error("state moved while clock enable low");

  AST_JUMP_HOLD: assert property (
    clkEn && !anyFire |=> !jumpValid && $stable(jumpRow) &&
      $stable(jumpAddr))
    else $error("jump outputs moved without a firing row");

  AST_JUMP_GATE: assert property (
    jumpValid && $past(clkEn) |-> $past(waitActive) &&
      (($past(waitRowEnable) >> jumpRow) & 5'h01) == 5'h01)
    else $error("jump from a disabled row");

  AST_JUMP_WRITTEN: assert property (
    jumpValid && $past(clkEn) |->
      (($past(rowValid) >> jumpRow) & 5'h01) == 5'h01)
    else $error("jump from an unwritten row");

  AST_FAR_DEST_ONE: assert property (
    clkEn && anyFire && table_q[firstRow].far &&
      table_q[firstRow].regSel |=>
      jumpAddr == $past(jumpRegisterSet[2*AW-1:AW]))
    else $error("far jump not through register one");

  AST_FAR_DEST_ZERO: assert property (
    clkEn && anyFire && table_q[firstRow].far &&
      !table_q[firstRow].regSel |=>
      jumpAddr == $past(jumpRegisterSet[AW-1:0]))
    else $error("far jump not through register zero");

  AST_REL_DEST: assert property (
    clkEn && anyFire && !table_q[firstRow].far |=>
      jumpAddr == $past(table_q[firstRow].addr))
    else $error("relative jump address wrong");

  COV_FAR: cover property (clkEn && isFar && rowOk ##1 entryWritten);
  COV_REL_NEG: cover property (clkEn && isRel && instrWord[13]);
  COV_MULTI: cover property (clkEn && $countones(rowFire) > 1);
  COV_ROUTE: cover property (clkEn && isCur ##1 route_q != ROUTE_RESET);
  COV_FAR_ZERO: cover property (clkEn && anyFire &&
    table_q[firstRow].far && !table_q[firstRow].regSel);
endmodule

// File: tb/wtd_seq_model.sv
// Sequencer model: feeds instruction words and wait requests.
// Assumes ref_clk from the bench; drives on the falling edge.
`timescale 1ns/1ps
module wtd_seq_model (
  input wire logic ref_clk,
  output logic instrValid,
  output logic [15:0] instrWord,
  output logic [wtd_pkg::ADDR_W-1:0] instrAddr,
  output logic waitActive,
  output logic [wtd_pkg::ROWS-1:0] waitRowEnable
);
  initial
  begin
    instrValid = 1'b0;
    instrWord = 16'h0000;
    instrAddr = 10'h000;
    waitActive = 1'b0;
    waitRowEnable = 5'h00;
  end
  // One word per call; released lines show the inverse
  task automatic issue(input logic [15:0] w, input logic [9:0] a);
    @(negedge ref_clk);
    instrValid = 1'b1;
    instrWord = w;
    instrAddr = a;
    @(negedge ref_clk);
    instrValid = 1'b0;
    instrWord = ~w;
    instrAddr = ~a;
  endtask
  task automatic waitRows(input logic [4:0] m);
    @(negedge ref_clk);
    waitActive = |m;
    waitRowEnable = m;
  endtask
endmodule

// File: tb/wait_table_entry_decoder_tb.sv
// Self-checking bench for the wait table entry decoder.
// Assumes core one, channel zero instance; sequencer model drives words.
`timescale 1ns/1ps
module wait_table_entry_decoder_tb;
  logic ref_clk, rstn, clkEn, instrValid, waitActive, aluDone;
  logic [15:0] instrWord, flags;
  logic [9:0] instrAddr;
  logic [4:0] waitRowEnable, rowValid;
  logic [19:0] jumpRegisterSet;
  logic [3:0] termCount;
  wtd_pkg::wtd_async_src_t extAsync;
  wtd_pkg::wtd_cur_route_t currentRouteSelector;
  logic entryWritten, routeWritten, ownCurrentFeedback, jumpValid;
  logic [2:0] jumpRow;
  logic [9:0] jumpAddr;
  int errCount = 0;
  int totalChecks = 0;

  wtd_seq_model seq (.ref_clk(ref_clk), .instrValid(instrValid),
    .instrWord(instrWord), .instrAddr(instrAddr), .waitActive(waitActive),
    .waitRowEnable(waitRowEnable));

  wtd_decoder #(.CORE_ID(1'b1), .CHANNEL_ID(1'b0)) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn),
    .instrValid(instrValid), .instrWord(instrWord), .instrAddr(instrAddr),
    .jumpRegisterSet(jumpRegisterSet), .waitActive(waitActive),
    .waitRowEnable(waitRowEnable), .flags(flags), .termCount(termCount),
    .aluDone(aluDone), .extAsync(extAsync), .entryWritten(entryWritten),
    .routeWritten(routeWritten),
    .currentRouteSelector(currentRouteSelector),
    .ownCurrentFeedback(ownCurrentFeedback), .rowValid(rowValid),
    .jumpValid(jumpValid), .jumpRow(jumpRow), .jumpAddr(jumpAddr));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] relW(input logic [4:0] o,
    input logic [2:0] r, input logic [5:0] c);
    return {2'h3, o, r, c};
  endfunction

  function automatic logic [15:0] farW(input logic g, input logic [2:0] r,
    input logic [5:0] c);
    return {6'h04, g, r, c};
  endfunction

  task automatic giveVerdict();
    $display("checks=%0d errors=%0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Fire check one edge after the wait is raised
  task automatic fireChk(input logic [4:0] m, input logic exp);
    seq.waitRows(m);
    @(negedge ref_clk);
    chk(jumpValid, exp);
    seq.waitRows(5'h00);
    @(negedge ref_clk);
  endtask

  task automatic tRoute();
    extAsync.curFb = 6'h0A;
    repeat (5) @(negedge ref_clk);
    for (int s = 0; s < 4; s++)
    begin
      seq.issue(16'h3578 | s[15:0], 10'h000);
      chk(routeWritten, 1'b1);
      chk(currentRouteSelector, s[15:0]);
      chk(ownCurrentFeedback, 16'((6'h0A >> s) & 6'h01));
    end
    seq.issue(16'h357C, 10'h000);
    chk(routeWritten, 1'b0);
    clkEn = 1'b0;
    seq.issue(16'h3578, 10'h000);
    clkEn = 1'b1;
    chk(currentRouteSelector, 16'h0003);
    extAsync.curFb = 6'h00;
  endtask

  task automatic tEntries();
    seq.issue(relW(5'h10, 3'h4, 6'h13), 10'h005);
    chk(entryWritten, 1'b1);
    chk(rowValid, 5'h10);
    flags = 16'h0008;
    fireChk(5'h10, 1'b1);
    chk(jumpRow, 16'h0004);
    chk(jumpAddr, 16'h03F5);
    @(negedge ref_clk);
    chk(jumpValid, 1'b0);
    seq.issue(relW(5'h0F, 3'h3, 6'h13), 10'h3FA);
    jumpRegisterSet = {10'h2A5, 10'h11B};
    seq.issue(farW(1'b1, 3'h0, 6'h20), 10'h050);
    chk(entryWritten, 1'b1);
    seq.issue(farW(1'b0, 3'h5, 6'h20), 10'h000);
    chk(entryWritten, 1'b0);
    chk(rowValid, 5'h19);
    termCount = 4'h1;
    fireChk(5'h19, 1'b1);
    chk(jumpRow, 16'h0000);
    chk(jumpAddr, 16'h02A5);
    fireChk(5'h18, 1'b1);
    chk(jumpAddr, 16'h0009);
    seq.issue(farW(1'b0, 3'h2, 6'h20), 10'h000);
    fireChk(5'h04, 1'b1);
    chk(jumpRow, 16'h0002);
    chk(jumpAddr, 16'h011B);
  endtask

  // Row two tested alone against one condition code
  task automatic condCase(input logic [5:0] c, input logic [15:0] fl,
    input logic [3:0] tc, input logic alu, input logic [13:0] ext,
    input logic exp);
    seq.issue(relW(5'h00, 3'h1, c), 10'h100);
    flags = fl;
    termCount = tc;
    aluDone = alu;
    extAsync = ext;
    repeat (5) @(negedge ref_clk);
    fireChk(5'h02, exp);
  endtask

  task automatic tConds();
    condCase(6'h05, 16'h0000, 4'h0, 1'b0, 14'h0000, 1'b1);
    condCase(6'h05, 16'h0020, 4'h0, 1'b0, 14'h0000, 1'b0);
    condCase(6'h1F, 16'h8000, 4'h0, 1'b0, 14'h0000, 1'b1);
    condCase(6'h22, 16'h0000, 4'h4, 1'b0, 14'h0000, 1'b1);
    condCase(6'h2F, 16'h0000, 4'h0, 1'b1, 14'h0000, 1'b1);
    condCase(6'h25, 16'h0000, 4'h0, 1'b0, 14'h2000, 1'b1);
    condCase(6'h24, 16'h0000, 4'h0, 1'b0, 14'h2000, 1'b0);
    condCase(6'h31, 16'h0000, 4'h0, 1'b0, 14'h0000, 1'b1);
    condCase(6'h27, 16'h0000, 4'h0, 1'b0, 14'h1400, 1'b1);
    condCase(6'h2A, 16'h0000, 4'h0, 1'b0, 14'h0280, 1'b1);
    condCase(6'h2E, 16'h0000, 4'h0, 1'b0, 14'h1000, 1'b1);
    condCase(6'h35, 16'h0000, 4'h0, 1'b0, 14'h0008, 1'b1);
    condCase(6'h3B, 16'h0000, 4'h0, 1'b0, 14'h0008, 1'b0);
    condCase(6'h3E, 16'h0000, 4'h0, 1'b0, 14'h0008, 1'b1);
  endtask

  initial
  begin
    #1000000;
    errCount++;
    giveVerdict();
  end

  initial
  begin
    rstn = 1'b0;
    clkEn = 1'b1;
    jumpRegisterSet = 20'h00000;
    flags = 16'h0000;
    termCount = 4'h0;
    aluDone = 1'b0;
    extAsync = 14'h0000;
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    chk(currentRouteSelector, 16'h0001);
    chk(rowValid, 5'h00);
    tRoute();
    tEntries();
    tConds();
    rstn = 1'b0;
    @(negedge ref_clk);
    rstn = 1'b1;
    chk(currentRouteSelector, 16'h0001);
    chk(rowValid, 5'h00);
    chk(jumpValid, 1'b0);
    giveVerdict();
  end
endmodule
